// ### chan_div_pkg.sv
// Constants of the cascaded channel clock divider: register map, fields and resets.
// Assumes a classic Wishbone slave with 32-bit data, one register per aligned word.
//
// Summary of operation
// - Second stage stays low for low-count field plus one input cycles.
// - Second stage stays high for high-count field plus one input cycles.
// - First stage uses its own low and high count nibbles, each plus one.
// - Phase offsets: second stage upper nibble, first stage lower nibble, reset zero.
// - Second-stage bypass stops its counter and passes its input clock through.
// - First-stage bypass stops its counter and passes its input clock through.
// - Sync-ignore bit zero obeys chip-level sync; one ignores it completely.
// - Force bit drives a static high; software must also set sync-ignore.
// - Second stage starts high when its start bit is one, else low.
// - First stage starts high when its start bit is one, else low.
// - Duty-cycle correction runs while the disable bit is zero.
package chan_div_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_FIRST_COUNTS = 10'h19E;
    localparam logic [9:0] IDX_PHASE_OFFSETS = 10'h19F;
    localparam logic [9:0] IDX_SECOND_COUNTS = 10'h1A0;
    localparam logic [9:0] IDX_DIVIDER_CONTROL = 10'h1A1;
    localparam logic [9:0] IDX_DUTY_CORRECTION = 10'h1A2;
    localparam logic [9:0] IDX_CHANNEL_STATUS = 10'h1A3;

    localparam int ADR_WIDTH = 12;
    localparam int IDX_LSB = 2;
    localparam int REG_WIDTH = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int NIB_HI_LSB = 4;
    localparam int NIB_LO_LSB = 0;
    localparam int NIB_WIDTH = 4;
    localparam int CTL_BYPASS_SECOND = 5;
    localparam int CTL_BYPASS_FIRST = 4;
    localparam int CTL_SYNC_IGNORE = 3;
    localparam int CTL_FORCE_HIGH = 2;
    localparam int CTL_START_SECOND = 1;
    localparam int CTL_START_FIRST = 0;
    localparam int DCC_DISABLE_BIT = 0;
    localparam int STAT_OUT = 0;
    localparam int STAT_FIRST = 1;
    localparam int STAT_SECOND = 2;
    localparam int STAT_HOLD = 3;
    localparam int STAT_DCC_LOCK = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_FIRST_COUNTS = 8'h00;
    localparam logic [7:0] RST_PHASE_OFFSETS = 8'h00;
    localparam logic [7:0] RST_SECOND_COUNTS = 8'h00;
    localparam logic [7:0] RST_DIVIDER_CONTROL = 8'h00;
    localparam logic [7:0] RST_DUTY_CORRECTION = 8'h00;
    localparam logic [7:0] DUTY_CORRECTION_MASK = 8'h01;
    localparam logic [7:0] DIVIDER_CONTROL_MASK = 8'h3F;

    // Period measure width; longest period is 32 x 32 clock cycles
    localparam int PERIOD_WIDTH = 11;

endpackage

// ### cascade_stage.sv
// One programmable divider stage: high and low counts, phase offset, start level, bypass.
// Assumes inTick marks one cycle of its input clock and inRise that input's rising edge.
`timescale 1ns/1ps
`default_nettype none
module cascade_stage
    import chan_div_pkg::*;
#(
    parameter int CW = NIB_WIDTH
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic inTick,
    input wire logic inRise,
    input wire logic inLevel,
    input wire logic bypass,
    input wire logic hold,
    input wire logic startHigh,
    input wire logic [CW-1:0] highCount,
    input wire logic [CW-1:0] lowCount,
    input wire logic [CW-1:0] phaseOffset,
    output logic outLevel,
    output logic outRise
);

    logic level_q;
    logic [CW:0] cnt_q;
    logic [CW:0] startLoad;
    logic wrap;

    assign startLoad = (startHigh ? {1'b0, highCount} : {1'b0, lowCount})
        + {1'b0, phaseOffset};
    assign wrap = inTick && (cnt_q == '0);

    ////////////////////////////////////////////////////////////////////////////////
    // Phase counter
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            level_q <= 1'b0;
            cnt_q <= '0;
        end
        else if (bypass)
        begin
            level_q <= startHigh;
            cnt_q <= '0;
        end
        else if (hold)
        begin
            level_q <= startHigh;
            cnt_q <= startLoad;
        end
        else if (wrap)
        begin
            level_q <= ~level_q;
            cnt_q <= level_q ? {1'b0, lowCount} : {1'b0, highCount};
        end
        else if (inTick)
        begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output select
    assign outLevel = bypass ? inLevel : level_q;
    assign outRise = bypass ? inRise : (wrap && !level_q);

endmodule
`default_nettype wire

// ### chan_div_top.sv
// Cascaded channel clock divider with its registers on a classic Wishbone slave.
// Assumes clk is the distribution clock and syncReq_n an asynchronous chip-level sync.
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module chan_div_top
    import chan_div_pkg::*;
#(
    parameter int PW = PERIOD_WIDTH
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic syncReq_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_WIDTH-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic chanOut
);

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] firstCounts_q;
    logic [7:0] phaseOffsets_q;
    logic [7:0] secondCounts_q;
    logic [7:0] dividerControl_q;
    logic [7:0] dutyCorrection_q;
    logic syncMeta_q;
    logic syncPin_q;
    logic hold;
    logic clkMirror_q;
    logic firstLevel;
    logic firstRise;
    logic secondLevel;
    logic secondRise;
    logic [PW-1:0] periodCnt_q;
    logic [PW-1:0] period_q;
    logic periodValid_q;
    logic [PW-1:0] halfPeriod;
    logic dccLevel;
    logic duty_correction_disable;
    logic forceOn;
    logic chanOut_q;
    logic chanOut_d;
    logic ack_q;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic access;
    logic writeLane;
    logic [9:0] idx;

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode
    function automatic logic [9:0] regIndex(input logic [ADR_WIDTH-1:0] adr);
        regIndex = adr[ADR_WIDTH-1:IDX_LSB];
    endfunction

    function automatic logic [NIB_WIDTH-1:0] nibble(input logic [7:0] val, input logic upper);
        nibble = upper ? val[NIB_HI_LSB +: NIB_WIDTH] : val[NIB_LO_LSB +: NIB_WIDTH];
    endfunction

    function automatic logic writeHit(input logic lane, input logic [9:0] hitIdx,
        input logic [9:0] target);
        writeHit = lane && (hitIdx == target);
    endfunction

    assign access = cyc_i && stb_i && !ack_q;
    assign writeLane = access && we_i && sel_i[0];
    assign idx = regIndex(adr_i);

    ////////////////////////////////////////////////////////////////////////////////
    // First-stage counts
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            firstCounts_q <= RST_FIRST_COUNTS;
        end
        else if (writeHit(writeLane, idx, IDX_FIRST_COUNTS))
        begin
            firstCounts_q <= dat_i[REG_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Phase offsets
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phaseOffsets_q <= RST_PHASE_OFFSETS;
        end
        else if (writeHit(writeLane, idx, IDX_PHASE_OFFSETS))
        begin
            phaseOffsets_q <= dat_i[REG_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Second-stage counts
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            secondCounts_q <= RST_SECOND_COUNTS;
        end
        else if (writeHit(writeLane, idx, IDX_SECOND_COUNTS))
        begin
            secondCounts_q <= dat_i[REG_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider control
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dividerControl_q <= RST_DIVIDER_CONTROL;
        end
        else if (writeHit(writeLane, idx, IDX_DIVIDER_CONTROL))
        begin
            dividerControl_q <= dat_i[REG_WIDTH-1:0] & DIVIDER_CONTROL_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Duty-cycle correction control
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dutyCorrection_q <= RST_DUTY_CORRECTION;
        end
        else if (writeHit(writeLane, idx, IDX_DUTY_CORRECTION))
        begin
            dutyCorrection_q <= dat_i[REG_WIDTH-1:0] & DUTY_CORRECTION_MASK;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sync pin synchroniser
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            syncMeta_q <= 1'b0;
            syncPin_q <= 1'b0;
        end
        else
        begin
            syncMeta_q <= !syncReq_n;
            syncPin_q <= syncMeta_q;
        end
    end

    assign hold = syncPin_q && !dividerControl_q[CTL_SYNC_IGNORE];

    ////////////////////////////////////////////////////////////////////////////////
    // Input clock mirror for a bypassed first stage
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clkMirror_q <= 1'b0;
        end
        else
        begin
            clkMirror_q <= ~clkMirror_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Divider stages
    cascade_stage #(
        .CW(NIB_WIDTH)
    ) firstStage (
        .clk(clk),
        .rst_n(rst_n),
        .inTick(1'b1),
        .inRise(1'b1),
        .inLevel(clkMirror_q),
        .bypass(dividerControl_q[CTL_BYPASS_FIRST]),
        .hold(hold),
        .startHigh(dividerControl_q[CTL_START_FIRST]),
        .highCount(nibble(firstCounts_q, 1'b0)),
        .lowCount(nibble(firstCounts_q, 1'b1)),
        .phaseOffset(nibble(phaseOffsets_q, 1'b0)),
        .outLevel(firstLevel),
        .outRise(firstRise)
    );

    cascade_stage #(
        .CW(NIB_WIDTH)
    ) secondStage (
        .clk(clk),
        .rst_n(rst_n),
        .inTick(firstRise),
        .inRise(firstRise),
        .inLevel(firstLevel),
        .bypass(dividerControl_q[CTL_BYPASS_SECOND]),
        .hold(hold),
        .startHigh(dividerControl_q[CTL_START_SECOND]),
        .highCount(nibble(secondCounts_q, 1'b0)),
        .lowCount(nibble(secondCounts_q, 1'b1)),
        .phaseOffset(nibble(phaseOffsets_q, 1'b1)),
        .outLevel(secondLevel),
        .outRise(secondRise)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Period measure for duty-cycle correction
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            periodCnt_q <= '0;
            period_q <= '0;
            periodValid_q <= 1'b0;
        end
        else if (hold || duty_correction_disable)
        begin
            periodCnt_q <= '0;
            periodValid_q <= 1'b0;
        end
        else if (secondRise)
        begin
            period_q <= periodCnt_q + 1'b1;
            periodCnt_q <= '0;
            periodValid_q <= 1'b1;
        end
        else if (periodCnt_q != '1)
        begin
            periodCnt_q <= periodCnt_q + 1'b1;
        end
    end

    assign duty_correction_disable = dutyCorrection_q[DCC_DISABLE_BIT];
    // Rounds up; one spare bit keeps a full count from wrapping
    assign halfPeriod = PW'(({1'b0, period_q} + 1'b1) >> 1);
    assign dccLevel = (periodCnt_q < halfPeriod);

    ////////////////////////////////////////////////////////////////////////////////
    // Channel output
    assign forceOn = dividerControl_q[CTL_FORCE_HIGH] && dividerControl_q[CTL_SYNC_IGNORE];

    always_comb
    begin
        if (forceOn)
        begin
            chanOut_d = 1'b1;
        end
        else if (duty_correction_disable || !periodValid_q)
        begin
            chanOut_d = secondLevel;
        end
        else
        begin
            chanOut_d = dccLevel;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            chanOut_q <= 1'b0;
        end
        else
        begin
            chanOut_q <= chanOut_d;
        end
    end

    assign chanOut = chanOut_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb
    begin
        dat_d = '0;
        case (idx)
            IDX_FIRST_COUNTS:
            begin
                dat_d[REG_WIDTH-1:0] = firstCounts_q;
            end
            IDX_PHASE_OFFSETS:
            begin
                dat_d[REG_WIDTH-1:0] = phaseOffsets_q;
            end
            IDX_SECOND_COUNTS:
            begin
                dat_d[REG_WIDTH-1:0] = secondCounts_q;
            end
            IDX_DIVIDER_CONTROL:
            begin
                dat_d[REG_WIDTH-1:0] = dividerControl_q;
            end
            IDX_DUTY_CORRECTION:
            begin
                dat_d[REG_WIDTH-1:0] = dutyCorrection_q;
            end
            IDX_CHANNEL_STATUS:
            begin
                dat_d[STAT_OUT] = chanOut_q;
                dat_d[STAT_FIRST] = firstLevel;
                dat_d[STAT_SECOND] = secondLevel;
                dat_d[STAT_HOLD] = hold;
                dat_d[STAT_DCC_LOCK] = periodValid_q;
            end
            default:
            begin
                dat_d = '0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end
        else
        begin
            ack_q <= access;
            dat_q <= (access && !we_i) ? dat_d : '0;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

endmodule
`default_nettype wire

// ### chan_div_top_properties.sv
// Checker of the channel divider: bus timing, readback, sync hold and forcing.
// Assumes it is bound to chan_div_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module chan_div_checker
    import chan_div_pkg::*;
#(
    parameter int PW = PERIOD_WIDTH
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic syncReq_n,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_WIDTH-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic chanOut
);
    logic [7:0] ctl_q;
    logic req;
    assign req = cyc_i && stb_i && !ack_o;
    ////////////////////////////////////////////////////////////////////////////////
    // Control register shadow
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctl_q <= 8'h00;
        end
        else if (req && we_i && sel_i[0] && adr_i[11:2] == IDX_DIVIDER_CONTROL)
        begin
            ctl_q <= dat_i[7:0] & DIVIDER_CONTROL_MASK;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // Properties
    AST_ACK_LATENCY: assert property (req |=> ack_o)
        else $error("ack missing after request");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (!req |=> !ack_o)
        else $error("ack without request");
    AST_DAT_IDLE: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    AST_DAT_UPPER: assert property (ack_o |-> dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    AST_CTL_READBACK: assert property ((req && !we_i
        && adr_i[11:2] == IDX_DIVIDER_CONTROL) |=> dat_o == {24'h0, ctl_q})
        else $error("control readback wrong");
    AST_HOLD_LOW: assert property ((!syncReq_n && ctl_q[5:3] == 3'h0 && !ctl_q[1])[*8]
        |-> !chanOut)
        else $error("output not low in hold");
    AST_HOLD_HIGH: assert property ((!syncReq_n && ctl_q[5:3] == 3'h0 && ctl_q[1])[*8]
        |-> chanOut)
        else $error("output not high in hold");
    AST_FORCE_HIGH: assert property ((ctl_q[5:2] == 4'h3)[*6] |-> chanOut)
        else $error("forced output not high");
endmodule
bind chan_div_top chan_div_checker #(.PW(PW)) chk_i (.clk(clk), .rst_n(rst_n),
    .syncReq_n(syncReq_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .chanOut(chanOut));
`default_nettype wire

// ### tb_chan_div_top.sv
// Testbench of the channel divider: registers, periods, sync hold, forcing, offsets.
// Assumes chan_div_pkg, chan_div_top and its checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_chan_div_top;
    import chan_div_pkg::*;
    logic clk, rst_n, syncReq_n, cyc, stb, we, ack, chanOut;
    logic [ADR_WIDTH-1:0] adr;
    logic [3:0] sel;
    logic [31:0] dat, q, datOut;
    int err_count = 0;
    int n_compared = 0;
    int d0, d;
    logic [7:0] msk [5] = '{8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h01};
    logic [7:0] cf [5] = '{8'h00, 8'h21, 8'h00, 8'h21, 8'h21};
    logic [7:0] cs [5] = '{8'h00, 8'h10, 8'h10, 8'h10, 8'h10};
    logic [7:0] cc [5] = '{8'h00, 8'h00, 8'h10, 8'h20, 8'h00};
    logic [7:0] cd [5] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h00};
    int eh [5] = '{2, 5, 1, 2, 8};
    int el [5] = '{2, 10, 2, 3, 7};
    logic [7:0] hc [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
    logic [7:0] hs [4] = '{8'h08, 8'h0A, 8'h0D, 8'h08};
    logic [7:0] offs [3] = '{8'h00, 8'h03, 8'h20};
    int oe [3] = '{0, 3, 4};
    chan_div_top dut (.clk(clk), .rst_n(rst_n), .syncReq_n(syncReq_n), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(datOut),
        .ack_o(ack), .chanOut(chanOut));
    ////////////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic complete_run;
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
    endtask
    task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] dv,
        input logic [3:0] s);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dat <= {24'h0, dv};
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        q = datOut;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 50)
        begin
            err_count++;
            complete_run();
        end
    endtask
    task automatic measure(input int xh, input int xl);
        int n, h, l;
        n = 0;
        h = 0;
        l = 0;
        while (chanOut !== 1'b0 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        while (chanOut !== 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        while (chanOut === 1'b1 && n < 2000)
        begin
            @(posedge clk);
            n++;
            h++;
        end
        while (chanOut === 1'b0 && n < 2000)
        begin
            @(posedge clk);
            n++;
            l++;
        end
        if (n >= 2000)
        begin
            err_count++;
            complete_run();
        end
        chk(32'(h), 32'(xh));
        chk(32'(l), 32'(xl));
    endtask
    task automatic syncDelay(output int dl);
        int n;
        syncReq_n <= 1'b0;
        tick(12);
        syncReq_n <= 1'b1;
        n = 0;
        while (chanOut !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 200)
        begin
            err_count++;
            complete_run();
        end
        dl = n;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Clock and sequence
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        rst_n = 1'b0;
        syncReq_n = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = '0;
        sel = '0;
        dat = '0;
        tick(10);
        rst_n <= 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b0, 10'(IDX_FIRST_COUNTS + i), 8'h00, 4'h1);
            chk(q, 32'h0);
            wb(1'b1, 10'(IDX_FIRST_COUNTS + i), 8'hFF, 4'h1);
            wb(1'b0, 10'(IDX_FIRST_COUNTS + i), 8'h00, 4'h1);
            chk(q, {24'h0, msk[i]});
        end
        wb(1'b1, 10'h1A4, 8'hFF, 4'h1);
        wb(1'b0, 10'h1A4, 8'h00, 4'h1);
        chk(q, 32'h0);
        wb(1'b1, IDX_FIRST_COUNTS, 8'h00, 4'h0);
        wb(1'b0, IDX_FIRST_COUNTS, 8'h00, 4'h1);
        chk(q, 32'hFF);
        wb(1'b1, IDX_PHASE_OFFSETS, 8'h00, 4'h1);
        for (int i = 0; i < 5; i++)
        begin
            wb(1'b1, IDX_FIRST_COUNTS, cf[i], 4'h1);
            wb(1'b1, IDX_SECOND_COUNTS, cs[i], 4'h1);
            wb(1'b1, IDX_DIVIDER_CONTROL, cc[i], 4'h1);
            wb(1'b1, IDX_DUTY_CORRECTION, cd[i], 4'h1);
            tick(100);
            measure(eh[i], el[i]);
        end
        wb(1'b0, IDX_CHANNEL_STATUS, 8'h00, 4'h1);
        chk(q & 32'h18, 32'h10);
        wb(1'b1, IDX_DUTY_CORRECTION, 8'h01, 4'h1);
        wb(1'b1, IDX_FIRST_COUNTS, 8'h00, 4'h1);
        wb(1'b1, IDX_SECOND_COUNTS, 8'h00, 4'h1);
        for (int i = 0; i < 4; i++)
        begin
            wb(1'b1, IDX_DIVIDER_CONTROL, hc[i], 4'h1);
            syncReq_n <= 1'b0;
            tick(12);
            wb(1'b0, IDX_CHANNEL_STATUS, 8'h00, 4'h1);
            chk(q & 32'hF, {24'h0, hs[i]});
            syncReq_n <= 1'b1;
            tick(4);
        end
        wb(1'b1, IDX_DIVIDER_CONTROL, 8'h08, 4'h1);
        syncReq_n <= 1'b0;
        tick(20);
        measure(2, 2);
        wb(1'b1, IDX_DIVIDER_CONTROL, 8'h0C, 4'h1);
        tick(8);
        repeat (8)
        begin
            tick(1);
            chk({31'h0, chanOut}, 32'h1);
        end
        wb(1'b1, IDX_DIVIDER_CONTROL, 8'h00, 4'h1);
        syncReq_n <= 1'b1;
        tick(8);
        for (int i = 0; i < 3; i++)
        begin
            wb(1'b1, IDX_PHASE_OFFSETS, offs[i], 4'h1);
            syncDelay(d);
            if (i == 0)
                d0 = d;
            chk(32'(d - d0), 32'(oe[i]));
        end
        complete_run();
    end
endmodule
`default_nettype wire
